// >>> include/rtc_trim_params.svh
`ifndef RTC_TRIM_PARAMS_SVH
`define RTC_TRIM_PARAMS_SVH

// Register offsets on the byte-wide register port
`define TRIM_REG_ADDR 4'h7
`define ALARM_MINUTE_REG_ADDR 4'h8
`define ALARM_HOUR_REG_ADDR 4'h9
`define ALARM_DAY_MASK_REG_ADDR 4'ha

// Reset values
`define TRIM_RESET 7'h00
`define ALARM_MINUTE_RESET 7'h00
`define ALARM_HOUR_RESET 6'h00
`define ALARM_DAY_MASK_RESET 7'h00
`define WEEKDAY_RESET 3'h0

// Trim register field positions
`define TRIM_SIGN_POS 6
`define TRIM_MAG_MSB 5
`define TRIM_MAG_LSB 0
`define TRIM_MID_MSB 5
`define TRIM_MID_LSB 1

// Time count constants
`define TRIM_BASE_PULSES 16'h8000
`define TRIM_POINT_SEC_00 7'h00
`define TRIM_POINT_SEC_20 7'h20
`define TRIM_POINT_SEC_40 7'h40
`define WEEKDAY_LAST 3'h6
`define WEEKDAY_FIRST 3'h0

// Delay from a match to the flag, in microseconds, then in cycles
`define SYS_CLK_PERIOD_NS 10
`define ALARM_SET_DELAY_US 61
`define ALARM_SET_DELAY_CYCLES ((`ALARM_SET_DELAY_US * 1000) / `SYS_CLK_PERIOD_NS)

`endif

// >>> include/rtc_trim_pkg.sv
package rtc_trim_pkg;

    typedef logic [7:0] reg_byte_t;

    typedef enum logic [1:0] {
        ALARM_IDLE,
        ALARM_WAIT,
        ALARM_HELD
    } alarm_state_e;

endpackage

// >>> rtl/weekday_alarm_match.sv
`timescale 1ns/1ps

module weekday_alarm_match (
    input wire logic [6:0] minute_i,
    input wire logic [5:0] hour_i,
    input wire logic [2:0] weekday_i,
    input wire logic [6:0] alarm_minute_i,
    input wire logic [5:0] alarm_hour_i,
    input wire logic [6:0] day_mask_i,
    output logic match_o
);

    // Day selection: weekday code n picks mask bit n
    logic [7:0] mask_ext;
    logic day_hit;
    logic minute_hit;
    logic hour_hit;

    assign mask_ext = {1'b0, day_mask_i};
    assign day_hit = mask_ext[weekday_i];
    // Code 7 reads the always-zero extension, so it never hits

    // Raw code compare; hour coding is the same in counter and alarm
    assign minute_hit = (minute_i == alarm_minute_i);
    assign hour_hit = (hour_i == alarm_hour_i);
    assign match_o = minute_hit && hour_hit && day_hit;

endmodule

// >>> rtl/rtc_trim_and_weekly_alarm.sv
// Function
// - Trim only seconds starting at 00/20/40
// - Nominal second is 32768 oscillator pulses
// - Trim write arms correction with new value
// - Write at correction point skips that point
// - Sign zero lengthens by (magnitude-1)*2
// - Sign one shortens by (~magnitude+1)*2
// - Middle five bits zero means no correction
// - Trim top bit always reads zero
// - Trim resets zero; unused alarm bits zero
// - Correction changes counts, not oscillator frequency
// - Hour bit five is PM or twenty
// - Twelve-hour zero coded 12 or 32
// - Mask bit n selects weekday code n
// - Empty day mask never matches
// - Flag cleared by writing zero or by disabling alarm
// - Flag reads zero while alarm disabled
// - Weekday counts modulo seven on carry
`timescale 1ns/1ps
`include "rtc_trim_params.svh"

module rtc_trim_and_weekly_alarm #(
    parameter int unsigned ALARM_SET_DELAY_CYCLES = `ALARM_SET_DELAY_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Oscillator pulse pin, asynchronous to sys_clk_i
    input wire logic osc_clk_i,
    // Byte register port
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rdata_valid_o,
    // Current time from the time counters
    input wire logic [6:0] seconds_i,
    input wire logic [6:0] minute_i,
    input wire logic [5:0] hour_i,
    input wire logic sub_second_clear_i,
    output logic second_tick_o,
    // Day-of-week counter
    input wire logic day_carry_i,
    input wire logic weekday_load_i,
    input wire logic [2:0] weekday_load_value_i,
    output logic [2:0] weekday_o,
    // Alarm control and status
    input wire logic weekly_alarm_enable_i,
    input wire logic alarm_flag_write_i,
    input wire logic alarm_flag_wdata_i,
    output logic weekly_alarm_flag_o,
    output logic weekly_alarm_irq_n_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic osc_pulse;

    logic [6:0] trim;
    logic [6:0] alarm_minute;
    logic [5:0] alarm_hour;
    logic [6:0] day_mask;
    logic [2:0] weekday;

    logic trim_active;
    logic skip_point;
    logic [15:0] pulse_count;
    logic second_tick;

    rtc_trim_pkg::alarm_state_e alarm_state;
    rtc_trim_pkg::alarm_state_e next_alarm_state;
    logic [15:0] delay_count;
    logic alarm_flag;
    logic alarm_match;

    logic wr_trim;
    logic wr_minute;
    logic wr_hour;
    logic wr_day_mask;
    logic hit_trim;
    logic hit_minute;
    logic hit_hour;
    logic hit_day_mask;
    rtc_trim_pkg::reg_byte_t read_value;

    logic trim_sign;
    logic [5:0] trim_mag;
    logic trim_mid_zero;
    logic at_point;
    logic apply_trim;
    logic [5:0] inc_steps;
    logic [5:0] dec_steps;
    logic [15:0] inc_pulses;
    logic [15:0] dec_pulses;
    logic [15:0] period;
    logic [15:0] period_last;
    logic period_done;

    logic [15:0] delay_last;
    logic delay_done;
    logic flag_set;
    logic flag_clear;
    logic [2:0] next_weekday;

    ////////////////////////////////////////////////////////////////////////
    // Oscillator pin synchroniser and pulse edge

    // Two flops before any logic; edge taken from the second only
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= osc_clk_i;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    // One cycle per rising oscillator edge
    assign osc_pulse = osc_sync && !osc_prev;

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    assign hit_trim = (reg_addr_i == `TRIM_REG_ADDR);
    assign hit_minute = (reg_addr_i == `ALARM_MINUTE_REG_ADDR);
    assign hit_hour = (reg_addr_i == `ALARM_HOUR_REG_ADDR);
    assign hit_day_mask = (reg_addr_i == `ALARM_DAY_MASK_REG_ADDR);
    assign wr_trim = reg_wr_i && hit_trim;
    assign wr_minute = reg_wr_i && hit_minute;
    assign wr_hour = reg_wr_i && hit_hour;
    assign wr_day_mask = reg_wr_i && hit_day_mask;

    // Register storage; only implemented bits are kept
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            trim <= `TRIM_RESET;
            alarm_minute <= `ALARM_MINUTE_RESET;
            alarm_hour <= `ALARM_HOUR_RESET;
            day_mask <= `ALARM_DAY_MASK_RESET;
        end else begin
            if (wr_trim) begin
                trim <= reg_wdata_i[6:0];
            end
            if (wr_minute) begin
                alarm_minute <= reg_wdata_i[6:0];
            end
            if (wr_hour) begin
                alarm_hour <= reg_wdata_i[5:0];
            end
            if (wr_day_mask) begin
                day_mask <= reg_wdata_i[6:0];
            end
        end
    end

    // Read mux; spare high bits and unmapped offsets read zero
    assign read_value = hit_trim ? {1'b0, trim} :
                        hit_minute ? {1'b0, alarm_minute} :
                        hit_hour ? {2'b00, alarm_hour} :
                        hit_day_mask ? {1'b0, day_mask} :
                        8'h00;

    // Read data is registered so it holds steady for the host
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
            reg_rdata_valid_o <= 1'b0;
        end else begin
            reg_rdata_valid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= read_value;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trim period arithmetic

    assign trim_sign = trim[`TRIM_SIGN_POS];
    assign trim_mag = trim[`TRIM_MAG_MSB:`TRIM_MAG_LSB];
    assign trim_mid_zero = (trim[`TRIM_MID_MSB:`TRIM_MID_LSB] == 5'h00);
    assign at_point = (seconds_i == `TRIM_POINT_SEC_00) ||
                      (seconds_i == `TRIM_POINT_SEC_20) ||
                      (seconds_i == `TRIM_POINT_SEC_40);

    // Mid-zero codes are excluded, so neither step count can wrap
    assign inc_steps = trim_mag - 6'h01;
    assign dec_steps = (~trim_mag) + 6'h01;
    assign inc_pulses = {9'h000, inc_steps, 1'b0};
    assign dec_pulses = {9'h000, dec_steps, 1'b0};

    // Correction only on armed, unskipped 00/20/40 seconds
    assign apply_trim = trim_active && at_point && !skip_point && !trim_mid_zero;

    // Only the count length moves; the oscillator itself is untouched
    assign period = !apply_trim ? `TRIM_BASE_PULSES :
                    trim_sign ? (`TRIM_BASE_PULSES - dec_pulses) :
                    (`TRIM_BASE_PULSES + inc_pulses);
    assign period_last = period - 16'h0001;
    assign period_done = osc_pulse && (pulse_count >= period_last);

    ////////////////////////////////////////////////////////////////////////
    // Sub-second divider

    // Compare with >= so a trim change mid-second cannot overrun
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pulse_count <= 16'h0000;
            second_tick <= 1'b0;
        end else begin
            second_tick <= period_done;
            if (sub_second_clear_i || period_done) begin
                pulse_count <= 16'h0000;
            end else if (osc_pulse) begin
                pulse_count <= pulse_count + 16'h0001;
            end
        end
    end

    assign second_tick_o = second_tick;

    ////////////////////////////////////////////////////////////////////////
    // Correction arming and skip

    // A write during a correction point suppresses only that point
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            trim_active <= 1'b0;
            skip_point <= 1'b0;
        end else begin
            if (wr_trim) begin
                trim_active <= 1'b1;
            end
            if (wr_trim && at_point) begin
                skip_point <= 1'b1;
            end else if (period_done || sub_second_clear_i) begin
                skip_point <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Day-of-week counter

    // Wrap from 6 to 0; a stray 7 also wraps to 0
    assign next_weekday = (weekday >= `WEEKDAY_LAST) ? `WEEKDAY_FIRST :
                          (weekday + 3'h1);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            weekday <= `WEEKDAY_RESET;
        end else if (weekday_load_i) begin
            weekday <= weekday_load_value_i;
        end else if (day_carry_i) begin
            weekday <= next_weekday;
        end
    end

    assign weekday_o = weekday;

    ////////////////////////////////////////////////////////////////////////
    // Alarm compare

    // Alarm values are trusted to be reachable times
    weekday_alarm_match u_match (
        .minute_i(minute_i),
        .hour_i(hour_i),
        .weekday_i(weekday),
        .alarm_minute_i(alarm_minute),
        .alarm_hour_i(alarm_hour),
        .day_mask_i(day_mask),
        .match_o(alarm_match)
    );

    ////////////////////////////////////////////////////////////////////////
    // Match sequencer: delay, set once, wait for match to end

    assign delay_last = 16'(ALARM_SET_DELAY_CYCLES - 1);
    assign delay_done = (delay_count >= delay_last);

    // Holding in ALARM_HELD stops one long match setting the flag twice
    always_comb begin
        next_alarm_state = alarm_state;
        case (alarm_state)
            rtc_trim_pkg::ALARM_IDLE: begin
                if (alarm_match && weekly_alarm_enable_i) begin
                    next_alarm_state = rtc_trim_pkg::ALARM_WAIT;
                end
            end
            rtc_trim_pkg::ALARM_WAIT: begin
                if (!alarm_match || !weekly_alarm_enable_i) begin
                    next_alarm_state = rtc_trim_pkg::ALARM_IDLE;
                end else if (delay_done) begin
                    next_alarm_state = rtc_trim_pkg::ALARM_HELD;
                end
            end
            rtc_trim_pkg::ALARM_HELD: begin
                if (!alarm_match) begin
                    next_alarm_state = rtc_trim_pkg::ALARM_IDLE;
                end
            end
            default: begin
                next_alarm_state = rtc_trim_pkg::ALARM_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            alarm_state <= rtc_trim_pkg::ALARM_IDLE;
            delay_count <= 16'h0000;
        end else begin
            alarm_state <= next_alarm_state;
            if (alarm_state == rtc_trim_pkg::ALARM_WAIT) begin
                delay_count <= delay_count + 16'h0001;
            end else begin
                delay_count <= 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm flag and interrupt pin

    assign flag_set = (alarm_state == rtc_trim_pkg::ALARM_WAIT) && delay_done &&
                      alarm_match && weekly_alarm_enable_i;
    assign flag_clear = alarm_flag_write_i && !alarm_flag_wdata_i;

    // Set beats clear in the same cycle so no match is lost
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            alarm_flag <= 1'b0;
        end else if (!weekly_alarm_enable_i) begin
            alarm_flag <= 1'b0;
        end else if (flag_set) begin
            alarm_flag <= 1'b1;
        end else if (flag_clear) begin
            alarm_flag <= 1'b0;
        end
    end

    // Pin low exactly while the flag is set
    assign weekly_alarm_flag_o = alarm_flag && weekly_alarm_enable_i;
    assign weekly_alarm_irq_n_o = !(alarm_flag && weekly_alarm_enable_i);

endmodule

// >>> test/osc_src.sv
`timescale 1ns/1ps

module osc_src (
    input wire logic clk_i,
    input wire logic run_i,
    output logic osc_o
);
    // Fastest pulse train the pin synchroniser can still resolve, to keep a second short
    initial osc_o = 1'b0;
    always @(posedge clk_i) begin
        osc_o <= #1 run_i ? ~osc_o : 1'b0;
    end
endmodule

// >>> test/rtc_alarm_chk.sv
`timescale 1ns/1ps

module rtc_alarm_chk #(
    parameter int unsigned ALARM_SET_DELAY_CYCLES = 6100
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rdata_valid_o,
    input wire logic second_tick_o,
    input wire logic day_carry_i,
    input wire logic weekday_load_i,
    input wire logic [2:0] weekday_o,
    input wire logic weekly_alarm_enable_i,
    input wire logic weekly_alarm_flag_o,
    input wire logic weekly_alarm_irq_n_o
);
    // Offset of the read whose data is on the port
    logic [3:0] rd_addr;
    always_ff @(posedge sys_clk_i) begin
        if (reg_rd_i) begin
            rd_addr <= reg_addr_i;
        end
    end

    // Cycles in a row with the alarm enabled, saturating; a flag needs the full set delay behind it
    logic [15:0] en_run;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !weekly_alarm_enable_i) begin
            en_run <= 16'h0000;
        end else if (en_run != 16'hffff) begin
            en_run <= en_run + 16'h0001;
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////
    a_irq_follows_flag: assert property (weekly_alarm_irq_n_o == !weekly_alarm_flag_o)
        else $error("alarm pin disagrees with flag");
    a_flag_needs_enable: assert property (!weekly_alarm_enable_i |-> !weekly_alarm_flag_o)
        else $error("flag set while alarm disabled");
    a_read_answers: assert property (reg_rd_i |=> reg_rdata_valid_o)
        else $error("read not answered");
    a_valid_has_cause: assert property (reg_rdata_valid_o |-> $past(reg_rd_i))
        else $error("read valid without read");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without read");
    a_trim_top_zero: assert property (reg_rdata_valid_o && rd_addr == 4'h7 |-> !reg_rdata_o[7])
        else $error("trim top bit reads one");
    a_unmapped_reads_zero: assert property (reg_rdata_valid_o && (rd_addr < 4'h7 || rd_addr > 4'ha)
        |-> reg_rdata_o == 8'h00)
        else $error("unmapped offset reads nonzero");
    a_weekday_wraps: assert property (day_carry_i && !weekday_load_i && weekday_o == 3'h6
        |=> weekday_o == 3'h0)
        else $error("weekday did not wrap");
    a_weekday_steps: assert property (day_carry_i && !weekday_load_i && weekday_o < 3'h6
        |=> weekday_o == $past(weekday_o) + 3'h1)
        else $error("weekday did not step");
    a_flag_after_delay: assert property ($rose(weekly_alarm_flag_o) |-> en_run >= 16'(ALARM_SET_DELAY_CYCLES))
        else $error("flag rose before the set delay");

    // Main scenarios reached
    c_flag_rise: cover property ($rose(weekly_alarm_flag_o));
    c_second_tick: cover property (second_tick_o);
    c_weekday_wrap: cover property (day_carry_i && weekday_o == 3'h6);
endmodule

bind rtc_trim_and_weekly_alarm rtc_alarm_chk #(.ALARM_SET_DELAY_CYCLES(ALARM_SET_DELAY_CYCLES)) chk (
    .sys_clk_i, .rst_n_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .reg_rdata_valid_o, .second_tick_o,
    .day_carry_i, .weekday_load_i, .weekday_o, .weekly_alarm_enable_i, .weekly_alarm_flag_o,
    .weekly_alarm_irq_n_o);

// >>> test/rtc_trim_and_weekly_alarm_tb.sv
`timescale 1ns/1ps

module rtc_trim_and_weekly_alarm_tb;
    localparam int unsigned DLY = 4;
    logic sys_clk_i = 1'b0;
    logic rst_n_i, reg_wr_i, reg_rd_i, sub_second_clear_i, day_carry_i, weekday_load_i, osc_run;
    logic weekly_alarm_enable_i, alarm_flag_write_i, alarm_flag_wdata_i, osc_clk_i;
    logic reg_rdata_valid_o, second_tick_o, weekly_alarm_flag_o, weekly_alarm_irq_n_o;
    logic [3:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o;
    logic [6:0] seconds_i, minute_i;
    logic [5:0] hour_i;
    logic [2:0] weekday_load_value_i, weekday_o;
    logic [31:0] lfsr = 32'h7f890c53;
    int mismatches = 0;
    int num_checks = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    osc_src osc (.clk_i(sys_clk_i), .run_i(osc_run), .osc_o(osc_clk_i));
    rtc_trim_and_weekly_alarm #(.ALARM_SET_DELAY_CYCLES(DLY)) uut (
        .sys_clk_i, .rst_n_i, .osc_clk_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
        .reg_rdata_valid_o, .seconds_i, .minute_i, .hour_i, .sub_second_clear_i, .second_tick_o,
        .day_carry_i, .weekday_load_i, .weekday_load_value_i, .weekday_o, .weekly_alarm_enable_i,
        .alarm_flag_write_i, .alarm_flag_wdata_i, .weekly_alarm_flag_o, .weekly_alarm_irq_n_o);

    ////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Spare bits and unmapped offsets read as zero
    function automatic logic [7:0] read_view(input logic [3:0] a, input logic [7:0] d);
        case (a)
            4'h7, 4'h8, 4'ha: return d & 8'h7f;
            4'h9: return d & 8'h3f;
            default: return 8'h00;
        endcase
    endfunction

    // Oscillator pulses in a corrected second
    function automatic int trim_len(input logic [6:0] t);
        if (t[5:1] == 5'h00) return 32768;
        if (!t[6]) return 32768 + 2 * (int'(t[5:0]) - 1);
        return 32768 - 2 * (int'(6'(~t[5:0])) + 1);
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // All drives land one step after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // Every strobe task lets one idle edge pass, so back-to-back calls never re-raise a strobe in one step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tick(1);
        reg_wr_i = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        tick(1);
        reg_rd_i = 1'b0;
        chk("rdata_valid", reg_rdata_valid_o, 1);
        chk("rdata", reg_rdata_o, exp);
        tick(1);
    endtask

    task automatic load_day(input logic [2:0] v);
        weekday_load_value_i = v;
        weekday_load_i = 1'b1;
        tick(1);
        weekday_load_i = 1'b0;
        tick(1);
    endtask

    task automatic pulse_carry();
        day_carry_i = 1'b1;
        tick(1);
        day_carry_i = 1'b0;
        tick(1);
    endtask

    task automatic flag_wr(input logic v);
        alarm_flag_write_i = 1'b1;
        alarm_flag_wdata_i = v;
        tick(1);
        alarm_flag_write_i = 1'b0;
        tick(1);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        logic [3:0] a;
        logic [7:0] d;
        logic [6:0] m;
        int n;
        rst_n_i = 1'b0;
        {reg_wr_i, reg_rd_i, sub_second_clear_i, day_carry_i, weekday_load_i, osc_run} = '0;
        {weekly_alarm_enable_i, alarm_flag_write_i, alarm_flag_wdata_i} = '0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 8'h00;
        seconds_i = 7'h21;
        minute_i = 7'h00;
        hour_i = 6'h32;
        weekday_load_value_i = 3'h0;
        tick(5);
        rst_n_i = 1'b1;
        rd(4'h7, 8'h00);
        // Random bytes over offsets 6..b, the two ends unmapped
        for (int i = 0; i < 24; i++) begin
            lfsr = next_rand(lfsr);
            a = 4'h6 + 4'(i % 6);
            d = lfsr[7:0] & ((a == 4'h7) ? 8'h7f : 8'hff);
            wr(a, d);
            rd(a, read_view(a, d));
        end
        $display("register test done");
        load_day(3'h6);
        pulse_carry();
        chk("weekday", weekday_o, 0);
        pulse_carry();
        chk("weekday", weekday_o, 1);
        $display("weekday test done");
        // Afternoon zero hour in twelve-hour coding, a reachable time
        wr(4'h8, 8'h59);
        wr(4'h9, 8'h32);
        weekly_alarm_enable_i = 1'b1;
        for (int j = 0; j < 9; j++) begin
            lfsr = next_rand(lfsr);
            m = (j == 0) ? 7'h00 : ((j == 1) ? 7'h7f : lfsr[6:0]);
            wr(4'ha, {1'b0, m});
            for (int w = 0; w < 7; w++) begin
                minute_i = 7'h00;
                load_day(3'(w));
                flag_wr(1'b0);
                minute_i = 7'h59;
                // Flag must still be low one cycle before the set delay runs out
                tick(DLY);
                chk("flag_early", weekly_alarm_flag_o, 0);
                tick(4);
                chk("alarm_flag", weekly_alarm_flag_o, m[w]);
                chk("alarm_irq_n", weekly_alarm_irq_n_o, !m[w]);
            end
        end
        flag_wr(1'b1);
        chk("flag_after_one", weekly_alarm_flag_o, m[6]);
        minute_i = 7'h00;
        flag_wr(1'b0);
        chk("flag_after_zero", weekly_alarm_flag_o, 0);
        wr(4'ha, 8'h40);
        minute_i = 7'h59;
        tick(DLY + 4);
        chk("flag_day_six", weekly_alarm_flag_o, 1);
        weekly_alarm_enable_i = 1'b0;
        tick(1);
        chk("flag_disabled", weekly_alarm_flag_o, 0);
        $display("alarm test done");
        // Trim written off a correction point, then a corrected second measured
        wr(4'h7, 8'h07);
        seconds_i = 7'h20;
        sub_second_clear_i = 1'b1;
        tick(1);
        sub_second_clear_i = 1'b0;
        osc_run = 1'b1;
        n = 0;
        while (second_tick_o !== 1'b1 && n < 70000) begin
            tick(1);
            n++;
        end
        // Pin synchroniser adds up to three pulses of lag
        n = n / 2;
        d = 8'h07;
        n = (n >= trim_len(d[6:0]) && n <= trim_len(d[6:0]) + 3) ? trim_len(d[6:0]) : n;
        chk("trim_pulses", n, trim_len(d[6:0]));
        $display("trim test done");
        end_sim();
    end

    // Whole run needs about 66500 cycles
    initial begin
        repeat (90000) @(posedge sys_clk_i);
        mismatches++;
        end_sim();
    end
endmodule
